// ===== rtl/t1co_pkg.sv
// Package with register map, field positions and types for the timer-one clock output block
package t1co_pkg;

   // ------------------------------------------------------------------
   // Register bus widths
   // ------------------------------------------------------------------
   localparam int ADDR_W = 8;                      // Register address width
   localparam int DATA_W = 8;                      // Register data width

   // ------------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_MODE_CTRL  = 8'h89; // Timer-one run, source, mode, flag
   localparam logic [7:0] ADDR_COUNT_LOW  = 8'h8a; // Count low byte / reload low byte
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'h8b; // Count high byte / reload high byte
   localparam logic [7:0] ADDR_AUX_CTRL   = 8'h8e; // Auxiliary control
   localparam logic [7:0] ADDR_CLKO_CTRL  = 8'h8f; // Interrupt enables and clock output control

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int BIT_TIMER0_CLKO  = 0;            // Timer-zero clock output enable
   localparam int BIT_TIMER1_CLKO  = 1;            // Timer-one clock output enable
   localparam int BIT_TIMER2_CLKO  = 2;            // Timer-two clock output enable
   localparam int BIT_MCLK_DIV_HI  = 3;            // Master clock divider select, high bit
   localparam int BIT_EXT_INT_TWO  = 4;            // External interrupt two enable
   localparam int BIT_EXT_INT_THR  = 5;            // External interrupt three enable
   localparam int BIT_EXT_INT_FOUR = 6;            // External interrupt four enable
   localparam int BIT_NO_PRESCALE  = 6;            // Aux control: timer one counts every clock
   localparam int BIT_RUN          = 0;            // Mode control: timer runs
   localparam int BIT_EXT_SOURCE   = 1;            // Mode control: count external pulses
   localparam int BIT_MODE_8BIT    = 2;            // Mode control: 8-bit auto-reload
   localparam int BIT_OVF_FLAG     = 7;            // Mode control: sticky overflow flag

   // ------------------------------------------------------------------
   // Reset values and masks
   // ------------------------------------------------------------------
   localparam logic [7:0] RST_CLKO_CTRL = 8'h00;   // Clock output control after reset
   localparam logic [7:0] RST_AUX_CTRL  = 8'h00;   // Aux control after reset
   localparam logic [7:0] MASK_CLKO     = 8'h7f;   // Top bit of clock output control reserved
   localparam logic [7:0] MASK_AUX      = 8'h40;   // Only the prescale bit is implemented
   localparam logic [7:0] BYTE_ZERO     = 8'h00;   // Idle read data
   localparam logic [7:0] BYTE_ONES     = 8'hff;   // Byte at its overflow point
   localparam logic [15:0] WORD_ZERO    = 16'h0000; // Counter reset value
   localparam logic [15:0] WORD_ONES    = 16'hffff; // Word at its overflow point

   // ------------------------------------------------------------------
   // Prescaler
   // ------------------------------------------------------------------
   localparam int PRESCALE_DIV = 12;               // Internal clock divided by twelve
   localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_DIV - 1); // Last prescaler state
   localparam logic [3:0] PRESCALE_ZERO = 4'h0;    // Prescaler start state

   // ------------------------------------------------------------------
   // Timer configuration carrier
   // ------------------------------------------------------------------
   typedef struct packed {
      logic run;                                   // Timer counts when set
      logic ext_source;                            // Count external pin instead of clock
      logic mode_8bit;                             // 8-bit auto-reload instead of 16-bit
   } t1co_cfg_t;

endpackage : t1co_pkg

// ===== rtl/t1co_top.sv
// Timer-one counter with programmable clock output on the shared port pin
`timescale 1ns/10ps
module t1co_top
   import t1co_pkg::*;
(
   input  wire logic              CLK_I,       // 10 MHz system clock
   input  wire logic              SYS_RST_I,   // Asynchronous reset, active high
   input  wire logic [ADDR_W-1:0] ADDR_I,      // Register address
   input  wire logic [DATA_W-1:0] WDATA_I,     // Register write data
   input  wire logic              WR_I,        // Write strobe
   input  wire logic              RD_I,        // Read strobe
   output logic      [DATA_W-1:0] RDATA_O,     // Read data, cycle after strobe
   input  wire logic              EXT_PULSE_I, // External count pin
   input  wire logic              CLKO_PIN_I,  // Shared pin level, input side
   output logic                   CLKO_PIN_O,  // Shared pin drive level
   output logic                   CLKO_PIN_OE_N_O, // Shared pin enable, low drives
   output logic                   TIMER0_IN_O  // Pin level for timer zero when not claimed
);

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   logic [7:0]  clko_ctrl;          // Interrupt enables and clock output control
   logic [7:0]  next_clko_ctrl;     // Next clock output control
   logic [7:0]  aux_ctrl;           // Auxiliary control
   logic [7:0]  next_aux_ctrl;      // Next auxiliary control
   t1co_cfg_t   cfg;                // Timer configuration
   t1co_cfg_t   next_cfg;           // Next timer configuration
   logic        ovf_flag;           // Sticky overflow flag
   logic        next_ovf_flag;      // Next overflow flag
   logic [7:0]  reload_low_byte;    // Hidden reload, low byte
   logic [7:0]  next_reload_low;    // Next reload low
   logic [7:0]  reload_high_byte;   // Hidden reload, high byte
   logic [7:0]  next_reload_high;   // Next reload high
   logic [15:0] count;              // Count, high byte above low byte
   logic [15:0] next_count;         // Next count
   logic [3:0]  prescale;           // Divide-by-twelve state
   logic [3:0]  next_prescale;      // Next prescale state
   logic        clk_out;            // Output toggle flip-flop
   logic        next_clk_out;       // Next toggle state
   logic [DATA_W-1:0] next_rdata;   // Next read data
   logic        ext_s1;             // Pin synchroniser, first stage
   logic        ext_s2;             // Pin synchroniser, second stage
   logic        ext_s3;             // Edge detector history
   logic        pin_s1;             // Shared pin synchroniser, first stage
   logic        pin_s2;             // Shared pin synchroniser, second stage
   logic        tick;               // One counted event this cycle
   logic        ovf;                // Timer overflow this cycle
   logic        clko_en;            // Timer-one clock output enabled
   logic        no_prescale;        // Count every clock
   logic        wr_mode;            // Write to mode control
   logic        wr_low;             // Write to count low byte
   logic        wr_high;            // Write to count high byte

   // ------------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------------
   assign clko_en     = clko_ctrl[BIT_TIMER1_CLKO];
   assign no_prescale = aux_ctrl[BIT_NO_PRESCALE];
   assign wr_mode     = WR_I && (ADDR_I == ADDR_MODE_CTRL);
   assign wr_low      = WR_I && (ADDR_I == ADDR_COUNT_LOW);
   assign wr_high     = WR_I && (ADDR_I == ADDR_COUNT_HIGH);

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------

   // External pins come from outside the clock domain
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
         ext_s3 <= 1'b0;
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
      end else begin
         ext_s1 <= EXT_PULSE_I;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
         pin_s1 <= CLKO_PIN_I;
         pin_s2 <= pin_s1;
      end
   end

   // ------------------------------------------------------------------
   // Count event selection
   // ------------------------------------------------------------------

   // One event per cycle at most; a stopped timer sees none
   always_comb begin
      tick = 1'b0;
      if (!cfg.run) begin
         tick = 1'b0;
      end else if (cfg.ext_source) begin
         // Falling edge on the pin, no fixed prescale
         tick = ext_s3 && !ext_s2;
      end else if (no_prescale) begin
         tick = 1'b1;
      end else begin
         tick = (prescale == PRESCALE_LAST);
      end
   end

   // Overflow point depends on the reload mode
   always_comb begin
      if (cfg.mode_8bit) begin
         ovf = tick && (count[7:0] == BYTE_ONES);
      end else begin
         ovf = tick && (count == WORD_ONES);
      end
   end

   // ------------------------------------------------------------------
   // Register file next state
   // ------------------------------------------------------------------

   // Software writes; hardware sets the flag
   always_comb begin
      next_clko_ctrl   = clko_ctrl;
      next_aux_ctrl    = aux_ctrl;
      next_cfg         = cfg;
      next_reload_low  = reload_low_byte;
      next_reload_high = reload_high_byte;
      next_ovf_flag    = ovf_flag;
      if (WR_I) begin
         if (ADDR_I == ADDR_CLKO_CTRL) begin
            next_clko_ctrl = WDATA_I & MASK_CLKO;
         end else if (ADDR_I == ADDR_AUX_CTRL) begin
            next_aux_ctrl = WDATA_I & MASK_AUX;
         end else if (ADDR_I == ADDR_MODE_CTRL) begin
            // Mode choice is left to software
            next_cfg.run        = WDATA_I[BIT_RUN];
            next_cfg.ext_source = WDATA_I[BIT_EXT_SOURCE];
            next_cfg.mode_8bit  = WDATA_I[BIT_MODE_8BIT];
            if (WDATA_I[BIT_OVF_FLAG]) begin
               next_ovf_flag = 1'b0; // Write one clears
            end
         end else if (ADDR_I == ADDR_COUNT_LOW) begin
            next_reload_low = WDATA_I;
         end else if (ADDR_I == ADDR_COUNT_HIGH) begin
            next_reload_high = WDATA_I;
         end
      end
      // A set in the clearing cycle is not lost
      if (ovf) begin
         next_ovf_flag = 1'b1;
      end
   end

   // Register file storage
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         clko_ctrl        <= RST_CLKO_CTRL;
         aux_ctrl         <= RST_AUX_CTRL;
         cfg              <= '0;
         reload_low_byte  <= BYTE_ZERO;
         reload_high_byte <= BYTE_ZERO;
         ovf_flag         <= 1'b0;
      end else begin
         clko_ctrl        <= next_clko_ctrl;
         aux_ctrl         <= next_aux_ctrl;
         cfg              <= next_cfg;
         reload_low_byte  <= next_reload_low;
         reload_high_byte <= next_reload_high;
         ovf_flag         <= next_ovf_flag;
      end
   end

   // ------------------------------------------------------------------
   // Timer next state
   // ------------------------------------------------------------------

   // Prescaler runs only while it is the selected source
   always_comb begin
      next_prescale = prescale;
      if (!cfg.run || cfg.ext_source || no_prescale) begin
         next_prescale = PRESCALE_ZERO;
      end else if (prescale == PRESCALE_LAST) begin
         next_prescale = PRESCALE_ZERO;
      end else begin
         next_prescale = prescale + 4'h1;
      end
   end

   // Counter with auto-reload; a stopped timer takes writes directly
   always_comb begin
      next_count = count;
      if (cfg.mode_8bit) begin
         if (ovf) begin
            next_count[7:0] = count[15:8];
         end else if (tick) begin
            next_count[7:0] = count[7:0] + 8'h01;
         end
         // In 8-bit mode the high byte is the reload and always writable
         if (wr_high) begin
            next_count[15:8] = WDATA_I;
         end
         if (wr_low && !cfg.run) begin
            next_count[7:0] = WDATA_I;
         end
      end else begin
         if (ovf) begin
            next_count = {reload_high_byte, reload_low_byte};
         end else if (tick) begin
            next_count = count + 16'h0001;
         end
         // While running, writes only reach the hidden reload
         if (wr_low && !cfg.run) begin
            next_count[7:0] = WDATA_I;
         end
         if (wr_high && !cfg.run) begin
            next_count[15:8] = WDATA_I;
         end
      end
   end

   // Output toggles once per overflow, holds while disabled
   always_comb begin
      next_clk_out = clk_out;
      if (clko_en && ovf) begin
         next_clk_out = !clk_out;
      end
   end

   // Timer storage
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         prescale <= PRESCALE_ZERO;
         count    <= WORD_ZERO;
         clk_out  <= 1'b0;
      end else begin
         prescale <= next_prescale;
         count    <= next_count;
         clk_out  <= next_clk_out;
      end
   end

   // ------------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------------

   // Data stands only in the cycle after the strobe
   always_comb begin
      next_rdata = BYTE_ZERO;
      if (RD_I) begin
         if (ADDR_I == ADDR_CLKO_CTRL) begin
            next_rdata = clko_ctrl;
         end else if (ADDR_I == ADDR_AUX_CTRL) begin
            next_rdata = aux_ctrl;
         end else if (ADDR_I == ADDR_MODE_CTRL) begin
            next_rdata = {ovf_flag, 4'h0, cfg.mode_8bit, cfg.ext_source, cfg.run};
         end else if (ADDR_I == ADDR_COUNT_LOW) begin
            next_rdata = count[7:0];
         end else if (ADDR_I == ADDR_COUNT_HIGH) begin
            next_rdata = count[15:8];
         end else begin
            next_rdata = BYTE_ZERO; // Unmapped reads as zero
         end
      end
   end

   // Read data register
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         RDATA_O <= BYTE_ZERO;
      end else begin
         RDATA_O <= next_rdata;
      end
   end

   // ------------------------------------------------------------------
   // Pin sharing
   // ------------------------------------------------------------------

   // Enable claims the pin; timer zero then sees a quiet low input
   assign CLKO_PIN_O      = clk_out;
   assign CLKO_PIN_OE_N_O = !clko_en;
   assign TIMER0_IN_O     = clko_en ? 1'b0 : pin_s2;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);

   a_pin_claim: assert property (
      CLKO_PIN_OE_N_O == !clko_ctrl[BIT_TIMER1_CLKO])
      else $error("Pin enable does not follow the output enable bit");

   a_toggle_ovf: assert property (
      (ovf && clko_en) |=> (CLKO_PIN_O != $past(CLKO_PIN_O)))
      else $error("Output did not toggle on overflow");

   a_only_ovf: assert property (
      !ovf |=> $stable(CLKO_PIN_O))
      else $error("Output changed without an overflow");

   a_hold_disabled: assert property (
      !clko_en |=> $stable(CLKO_PIN_O))
      else $error("Output changed while disabled");

   a_no_prescale: assert property (
      (cfg.run && !cfg.ext_source && no_prescale && !cfg.mode_8bit && !ovf && !WR_I)
      |=> (count == $past(count) + 16'h0001))
      else $error("Undivided mode missed a tick");

   a_prescale_gap: assert property (
      (tick && cfg.run && !cfg.ext_source && !no_prescale && $stable(aux_ctrl)
       && $stable(cfg)) |=> !tick [*8])
      else $error("Divided ticks came too close");

   a_ext_edge: assert property (
      (tick && cfg.ext_source) |=> !tick)
      else $error("External ticks on consecutive cycles");

   a_reload_16: assert property (
      (ovf && !cfg.mode_8bit && !wr_low && !wr_high)
      |=> (count == {reload_high_byte, reload_low_byte}))
      else $error("16-bit reload value not loaded");

   a_reload_8: assert property (
      (ovf && cfg.mode_8bit && !WR_I) |=> (count[7:0] == count[15:8]))
      else $error("8-bit reload value not loaded");

   a_stopped_quiet: assert property (
      !cfg.run |-> !ovf ##1 $stable(CLKO_PIN_O))
      else $error("Stopped timer overflowed");

   a_flag_sets: assert property (
      ovf |=> ovf_flag)
      else $error("Overflow flag not set");

   a_read_idle: assert property (
      !RD_I |=> (RDATA_O == BYTE_ZERO))
      else $error("Read data outside the answer cycle");

   c_toggle_16: cover property (ovf && clko_en && !cfg.mode_8bit);
   c_toggle_8: cover property (ovf && clko_en && cfg.mode_8bit);
   c_ext_ovf: cover property (ovf && cfg.ext_source);
   c_div_ovf: cover property (ovf && !cfg.ext_source && !no_prescale);

endmodule // t1co_top

// ===== test/t1co_clk_sink.sv
// Model of the circuit that receives the divided clock on the shared pin
`timescale 1ns/10ps
module t1co_clk_sink (
   input  wire logic        clk_i,     // System clock
   input  wire logic        rst_i,     // Reset, active high
   input  wire logic        drv_i,     // Level driven by the block
   input  wire logic        oe_n_i,    // Low while the block drives
   input  wire logic        far_lvl_i, // Level this circuit puts on a released pin
   output logic             pin_o,     // Resolved pin level
   output logic [15:0]      edges_o,   // Pin transitions seen
   output logic [15:0]      half_o     // Cycles between the last two transitions
);
   // ---------------------------------------------------------------
   // Pin resolution and period measurement
   // ---------------------------------------------------------------
   logic        prev;                  // Pin level one cycle ago
   logic [15:0] cnt;                   // Cycles since last transition

   // Released pin shows what this circuit drives, never the old level
   assign pin_o = oe_n_i ? far_lvl_i : drv_i;

   // Count cycles between transitions; two transitions make one period
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         prev    <= 1'b0;
         cnt     <= 16'h0000;
         edges_o <= 16'h0000;
         half_o  <= 16'h0000;
      end else begin
         prev <= pin_o;
         if (pin_o != prev) begin       // Transition seen
            half_o  <= cnt;
            cnt     <= 16'h0001;
            edges_o <= edges_o + 16'h0001;
         end else begin
            cnt <= cnt + 16'h0001;
         end
      end
   end
endmodule // t1co_clk_sink

// ===== test/timer1_programmable_clock_out_tb.sv
// Self-checking bench for the timer-one clock output block
`timescale 1ns/10ps
module timer1_programmable_clock_out_tb;
   import t1co_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   typedef struct {
      logic [7:0]  aux;   // Prescale select
      logic [7:0]  mode;  // Run, source, width
      logic [7:0]  hi;    // Reload high byte
      logic [7:0]  lo;    // Reload low byte
      logic [15:0] half;  // Expected cycles between pin transitions
   } t1co_row_t;
   logic              CLK_I, SYS_RST_I, WR_I, RD_I, EXT_PULSE_I, far_lvl;
   logic [7:0]        ADDR_I, WDATA_I, RDATA_O, rd_val;
   logic              CLKO_PIN_O, CLKO_PIN_OE_N_O, TIMER0_IN_O, pin, lvl;
   logic [15:0]       edges, half, snap;
   logic [3:0]        pcnt;           // External pulse divider
   int                num_errors, compares;
   t1co_row_t         rows [6];

   t1co_top t1co_top_i (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .ADDR_I(ADDR_I),
      .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
      .EXT_PULSE_I(EXT_PULSE_I), .CLKO_PIN_I(pin), .CLKO_PIN_O(CLKO_PIN_O),
      .CLKO_PIN_OE_N_O(CLKO_PIN_OE_N_O), .TIMER0_IN_O(TIMER0_IN_O));
   t1co_clk_sink t1co_clk_sink_i (.clk_i(CLK_I), .rst_i(SYS_RST_I), .drv_i(CLKO_PIN_O),
      .oe_n_i(CLKO_PIN_OE_N_O), .far_lvl_i(far_lvl), .pin_o(pin), .edges_o(edges),
      .half_o(half));

   // ---------------------------------------------------------------
   // Clock, external pulses, watchdog
   // ---------------------------------------------------------------
   initial begin
      CLK_I = 1'b0;
      forever #50 CLK_I = ~CLK_I;
   end
   // Pin toggles every 5 cycles: one falling edge per 10 cycles
   always @(posedge CLK_I) begin
      pcnt <= (pcnt == 4'h4) ? 4'h0 : pcnt + 4'h1;
      if (pcnt == 4'h4) EXT_PULSE_I <= ~EXT_PULSE_I;
   end
   // Whole run is some 1000 cycles; allow a wide margin
   initial begin
      repeat (40000) @(posedge CLK_I);
      num_errors = num_errors + 1;
      results();
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK_I);
      WR_I <= 1'b1; ADDR_I <= a; WDATA_I <= d;
      @(posedge CLK_I);
      WR_I <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge CLK_I);
      RD_I <= 1'b1; ADDR_I <= a;
      @(posedge CLK_I);
      RD_I <= 1'b0;
      @(negedge CLK_I);
      rd_val = RDATA_O;
   endtask
   task automatic wait_edges(input int n);
      int i;
      snap = edges;
      for (i = 0; i < 2000 && edges < snap + 16'(n); i++) @(posedge CLK_I);
      // Look at outputs only once they have settled
      @(negedge CLK_I);
   endtask
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      num_errors = 0; compares = 0; pcnt = 4'h0; far_lvl = 1'b1;
      SYS_RST_I = 1'b1; WR_I = 1'b0; RD_I = 1'b0;
      ADDR_I = 8'h00; WDATA_I = 8'h00; EXT_PULSE_I = 1'b1;
      rows[0] = '{8'h40, 8'h01, 8'hff, 8'hf0, 16'h0010}; // 16-bit, every clock
      rows[1] = '{8'h00, 8'h01, 8'hff, 8'hfc, 16'h0030}; // 16-bit, divided by 12
      rows[2] = '{8'h40, 8'h05, 8'hf8, 8'hf8, 16'h0008}; // 8-bit, every clock
      rows[3] = '{8'h00, 8'h05, 8'hfe, 8'hfe, 16'h0018}; // 8-bit, divided by 12
      rows[4] = '{8'h40, 8'h03, 8'hff, 8'hfc, 16'h0028}; // External pulses
      rows[5] = '{8'h00, 8'h07, 8'hfc, 8'hfc, 16'h0028}; // External, 8-bit
      repeat (2) @(posedge CLK_I);
      SYS_RST_I <= 1'b0;
      // Reset state of pin and registers
      chk({14'h0, CLKO_PIN_OE_N_O, CLKO_PIN_O}, 16'h0002);
      rd(ADDR_CLKO_CTRL); chk({8'h0, rd_val}, {8'h0, RST_CLKO_CTRL});
      rd(ADDR_AUX_CTRL); chk({8'h0, rd_val}, {8'h0, RST_AUX_CTRL});
      wr(ADDR_CLKO_CTRL, 8'hff);
      rd(ADDR_CLKO_CTRL); chk({8'h0, rd_val}, 16'h007f);
      wr(ADDR_AUX_CTRL, 8'hff);
      rd(ADDR_AUX_CTRL); chk({8'h0, rd_val}, 16'h0040);
      rd(8'h00); chk({8'h0, rd_val}, 16'h0000);
      // Ordinary cases: one row per mode, prescale and source
      foreach (rows[k]) begin
         wr(ADDR_MODE_CTRL, 8'h00);
         wr(ADDR_COUNT_LOW, rows[k].lo);
         wr(ADDR_COUNT_HIGH, rows[k].hi);
         wr(ADDR_AUX_CTRL, rows[k].aux);
         wr(ADDR_MODE_CTRL, rows[k].mode);
         wr(ADDR_CLKO_CTRL, 8'h02);
         wait_edges(3);
         chk(half, rows[k].half);
         chk({14'h0, CLKO_PIN_OE_N_O, TIMER0_IN_O}, 16'h0000);
      end
      // Disabled output holds its level and frees the pin
      wr(ADDR_CLKO_CTRL, 8'h00);
      // Let the released pin settle before counting transitions
      repeat (2) @(posedge CLK_I);
      snap = edges;
      lvl = CLKO_PIN_O;
      repeat (100) @(posedge CLK_I);
      @(negedge CLK_I);
      chk(edges, snap);
      chk({15'h0, CLKO_PIN_O}, {15'h0, lvl});
      chk({14'h0, CLKO_PIN_OE_N_O, TIMER0_IN_O}, 16'h0003);
      far_lvl <= 1'b0;
      repeat (4) @(posedge CLK_I);
      chk({15'h0, TIMER0_IN_O}, 16'h0000);
      // Stopped timer gives no transitions even when enabled
      wr(ADDR_MODE_CTRL, 8'h00);
      rd(ADDR_MODE_CTRL); chk({8'h0, rd_val}, 16'h0080);
      wr(ADDR_MODE_CTRL, 8'h80);
      rd(ADDR_MODE_CTRL); chk({8'h0, rd_val}, 16'h0000);
      wr(ADDR_CLKO_CTRL, 8'h02);
      repeat (2) @(posedge CLK_I);
      snap = edges;
      repeat (100) @(posedge CLK_I);
      chk(edges, snap);
      // Restart from a short count, then reset in mid-run drops the pin low
      wr(ADDR_COUNT_HIGH, 8'hff);
      wr(ADDR_COUNT_LOW, 8'hf0);
      rd(ADDR_COUNT_LOW); chk({8'h0, rd_val}, 16'h00f0);
      wr(ADDR_MODE_CTRL, 8'h01);
      wait_edges(1);
      chk({15'h0, CLKO_PIN_O}, {15'h0, ~lvl});
      @(posedge CLK_I);
      SYS_RST_I <= 1'b1;
      @(posedge CLK_I);
      SYS_RST_I <= 1'b0;
      @(negedge CLK_I);
      chk({14'h0, CLKO_PIN_OE_N_O, CLKO_PIN_O}, 16'h0002);
      results();
   end
endmodule // timer1_programmable_clock_out_tb
